// ---- src/wws_pkg.sv ----
// wws_pkg: constants, types and register map of the wake-up / watchdog / reset supervisor.
// assumes a single 200 MHz clock; the timing resistor value is held in ohms by software.
package wws_pkg;

  // ==========================================================================
  // clock and timing, all derived from one resistor setting
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_TENTHS_NS = 50;    // 5.0 ns clock period, in 0.1 ns
  // times per ohm of the timing resistor, in 0.1 ns
  localparam int unsigned RST_DELAY_TENTHS_NS  = 521;   // 5.21e-8 s per ohm
  localparam int unsigned WAKE_PERIOD_TENTHS_NS = 4170; // 4.17e-7 s per ohm
  localparam int unsigned RST_TO_WAKE_TENTHS_NS = 2080; // 2.08e-7 s per ohm

  // base tick equals the reset delay; other times are whole numbers of ticks
  localparam int unsigned HALF_TICKS_I =
    (WAKE_PERIOD_TENTHS_NS / 2 + RST_DELAY_TENTHS_NS / 2) / RST_DELAY_TENTHS_NS;
  localparam int unsigned RHW_TICKS_I =
    (RST_TO_WAKE_TENTHS_NS + RST_DELAY_TENTHS_NS / 2) / RST_DELAY_TENTHS_NS;

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] HALF_TICKS  = CNT_W'(HALF_TICKS_I);
  localparam logic [CNT_W-1:0] CYCLE_TICKS = CNT_W'(2 * HALF_TICKS_I);
  localparam logic [CNT_W-1:0] RHW_TICKS   = CNT_W'(RHW_TICKS_I);

  // prescaler phase accumulator: one resistor ohm per wrap
  localparam int unsigned ACC_W = 11;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_TENTHS_NS);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(RST_DELAY_TENTHS_NS);

  // ==========================================================================
  // register map (word addresses on the avalon slave)
  // ==========================================================================
  localparam int unsigned ADDR_W  = 2;
  localparam int unsigned RDLY_W  = 20;
  localparam logic [ADDR_W-1:0] REG_RDELAY = 2'h0;  // timing resistor, ohms, rw
  localparam logic [ADDR_W-1:0] REG_STATUS = 2'h1;  // supervisor state, ro
  localparam logic [RDLY_W-1:0] RDELAY_RST = 20'h0EA60; // 60 kohm

  // status field positions
  localparam int unsigned ST_RESET_N = 0;
  localparam int unsigned ST_WAKEUP  = 1;
  localparam int unsigned ST_REG_ON  = 2;
  localparam int unsigned ST_SEEN    = 3;
  localparam int unsigned ST_OUT_OK  = 4;
  localparam int unsigned ST_IN_OK   = 5;
  localparam int unsigned ST_TOCNT   = 8;   // 8-bit watchdog timeout count
  localparam int unsigned ST_CAUSE   = 16;  // 2-bit last reset cause

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    WWS_CAUSE_POWER, WWS_CAUSE_OUTPUT, WWS_CAUSE_INPUT, WWS_CAUSE_WDOG
  } wws_cause_t;

  typedef enum {WWS_HOLD, WWS_RHW, WWS_CYCLE} wws_state_t;

  // pins that come from outside the clock domain
  typedef struct packed {
    logic watchdog;   // watchdog_input from the microcontroller
    logic out_good;   // regulated_output in regulation
    logic in_good;    // supply_input high enough for control
    logic enable;     // regulator enable
  } wws_pins_t;

endpackage

// ---- src/wws_sync.sv ----
// wws_sync: two-flop synchroniser for the asynchronous supervisor pins.
// assumes every bit is an independent level; no bit relation is kept.
`timescale 1ns/1ps
module wws_sync
  import wws_pkg::*;
(
  input  wire logic      ref_clk_i, // 200 MHz clock
  input  wire logic      reset_i,   // synchronous reset, high
  input  wire wws_pins_t pins_i,    // raw pins
  output      wws_pins_t pins_o     // synchronised pins
);

  // ==========================================================================
  // two stages; the first is read only by the second
  // ==========================================================================
  wws_pins_t meta_q;
  wws_pins_t meta_d;
  wws_pins_t sync_q;

  always_comb begin
    meta_d = pins_i;
  end

  // reset to zero so nothing looks good or enabled before sampling
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= meta_q;
    end
  end

  assign pins_o = sync_q;

endmodule

// ---- src/wws_tick.sv ----
// wws_tick: prescaler giving one pulse per reset delay of the timing resistor.
// assumes rdelay_i is stable while a tick is in progress; a change applies at once.
`timescale 1ns/1ps
module wws_tick
  import wws_pkg::*;
(
  input  wire logic              ref_clk_i, // 200 MHz clock
  input  wire logic              reset_i,   // synchronous reset, high
  input  wire logic              clr_i,     // restart the tick from zero
  input  wire logic [RDLY_W-1:0] rdelay_i,  // resistor value in ohms
  output      logic              tick_o     // one-cycle pulse per tick
);

  logic [ACC_W-1:0]  acc_q, acc_d;
  logic [RDLY_W-1:0] ohm_q, ohm_d;
  logic              tick_q, tick_d;
  logic [ACC_W-1:0]  acc_sum;
  logic [RDLY_W:0]   ohm_next;

  // ==========================================================================
  // fractional accumulator: 10.42 clocks per ohm without a divider
  // ==========================================================================
  always_comb begin
    acc_sum  = acc_q + ACC_STEP;
    ohm_next = {1'b0, ohm_q} + {{RDLY_W{1'b0}}, 1'b1};
    acc_d    = acc_sum;
    ohm_d    = ohm_q;
    tick_d   = 1'b0;
    if (clr_i) begin
      acc_d = '0;
      ohm_d = '0;
    end else if (acc_sum >= ACC_WRAP) begin
      acc_d = acc_sum - ACC_WRAP;
      // a zero setting ticks every ohm step rather than hanging
      if (ohm_next >= {1'b0, rdelay_i}) begin
        ohm_d  = '0;
        tick_d = 1'b1;
      end else begin
        ohm_d = ohm_next[RDLY_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_q  <= '0;
      ohm_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      ohm_q  <= ohm_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// ---- src/wws_top.sv ----
// wws_top: wake-up square wave, watchdog edge check and active-low reset supervisor.
// assumes raw pins from outside the clock domain and an avalon-mm master on ref_clk_i.
`timescale 1ns/1ps

// What this block does
// - wake-up output is a square wave, high half and low half of each period.
// - wake-up period is 4.17e-7 seconds per ohm of the timing resistor.
// - reset delay is 5.21e-8 seconds per ohm of the timing resistor.
// - reset high to next wake-up rising edge takes 2.08e-7 seconds per ohm.
// - all three times come from the one timing-resistor setting.
// - only watchdog falling edges count; one is needed every wake-up period.
// - a valid watchdog falling edge forces wake-up low for the rest of the cycle.
// - further watchdog pulses in the same cycle are ignored.
// - a cycle without a watchdog falling edge ends in a reset pulse.
// - reset_n is active low for power-up, output low, timeout or input low.
// - at power-up reset_n stays low until the output is in regulation.
// - output below threshold drives reset_n low until recovery plus one reset delay.
// - supply input too low asserts reset_n whatever the output level.
// - wake-up stays low while reset_n is asserted.
// - when reset_n returns high the wake-up cycle restarts from its beginning.
// - enable high turns the regulator on, low shuts it down.
module wws_top
  import wws_pkg::*;
#(
  parameter logic [RDLY_W-1:0] RDELAY_DEFAULT = RDELAY_RST  // resistor at reset, ohms
)
(
  input  wire logic              ref_clk_i,          // 200 MHz clock
  input  wire logic              reset_i,            // synchronous reset, high
  input  wire logic              watchdog_input_i,   // watchdog pulse from the microcontroller
  input  wire logic              out_good_i,         // regulated_output in regulation
  input  wire logic              in_good_i,          // supply_input above control minimum
  input  wire logic              enable_i,           // regulator enable pin
  output      logic              reset_n_o,          // supervisor reset, active low
  output      logic              wakeup_o,           // wake-up square wave
  output      logic              regulator_on_o,     // pass device on
  input  wire logic [ADDR_W-1:0] avs_address_i,      // word address
  input  wire logic              avs_read_i,         // read request
  input  wire logic              avs_write_i,        // write request
  input  wire logic [31:0]       avs_writedata_i,    // write data
  input  wire logic [3:0]        avs_byteenable_i,   // byte lanes
  output      logic [31:0]       avs_readdata_o,     // read data
  output      logic              avs_waitrequest_o   // stall, low for one answer cycle
);
  import wws_pkg::*;

  // ==========================================================================
  // pin synchronisers and time base
  // ==========================================================================
  wws_pins_t pins_raw;
  wws_pins_t pins_s;
  logic      tick;
  logic      tick_clr;
  logic [RDLY_W-1:0] rdelay_q, rdelay_d;

  assign pins_raw = '{watchdog: watchdog_input_i, out_good: out_good_i,
                      in_good: in_good_i, enable: enable_i};

  // every pin passes two flops before any decision
  wws_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .pins_i    (pins_raw),
    .pins_o    (pins_s)
  );

  // one tick per reset delay, scaled from the resistor register
  wws_tick u_tick (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clr_i     (tick_clr),
    .rdelay_i  (rdelay_q),
    .tick_o    (tick)
  );

  // ==========================================================================
  // watchdog edge detect on the synchronised level
  // ==========================================================================
  logic wd_prev_q, wd_prev_d;
  logic wd_fall;
  logic out_ok;

  always_comb begin
    wd_prev_d = pins_s.watchdog;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wd_prev_q <= 1'b0;
    end else begin
      wd_prev_q <= wd_prev_d;
    end
  end

  // rising edges are never looked at
  assign wd_fall = wd_prev_q & ~pins_s.watchdog;
  // a shut-down regulator cannot hold the output, so treat it as out of regulation
  assign out_ok  = pins_s.out_good & pins_s.enable;

  // ==========================================================================
  // supervisor state machine
  // ==========================================================================
  wws_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             seen_q, seen_d;
  logic             reset_n_q, reset_n_d;
  logic             wake_q, wake_d;
  logic             reg_on_q, reg_on_d;
  wws_cause_t       cause_q, cause_d;
  logic [7:0]       tocnt_q, tocnt_d;
  logic             cyc_end;

  assign cyc_end = tick && (cnt_q == CYCLE_TICKS - 4'h1);

  // next state; faults override every state so reset follows them at once
  always_comb begin
    state_d  = state_q;
    seen_d   = seen_q;
    cause_d  = cause_q;
    tocnt_d  = tocnt_q;
    reg_on_d = pins_s.enable;
    if (!pins_s.in_good) begin
      state_d = WWS_HOLD;
      cause_d = WWS_CAUSE_INPUT;
    end else if (!out_ok) begin
      state_d = WWS_HOLD;
      if (state_q != WWS_HOLD) begin
        cause_d = WWS_CAUSE_OUTPUT;
      end
    end else begin
      case (state_q)
        // hold until a full tick has passed with everything good
        WWS_HOLD: begin
          if (tick) begin
            state_d = WWS_RHW;
          end
        end
        // reset released, wait before the first wake-up rise
        WWS_RHW: begin
          if (tick && (cnt_q == RHW_TICKS - 4'h1)) begin
            state_d = WWS_CYCLE;
          end
        end
        // one wake-up period of CYCLE_TICKS ticks
        WWS_CYCLE: begin
          if (wd_fall) begin
            seen_d = 1'b1;
          end
          if (cyc_end) begin
            if (seen_q || wd_fall) begin
              seen_d = 1'b0;
            end else begin
              state_d = WWS_HOLD;
              cause_d = WWS_CAUSE_WDOG;
              if (tocnt_q != 8'hFF) begin
                tocnt_d = tocnt_q + 8'h01;
              end
            end
          end
        end
        default: begin
          state_d = WWS_HOLD;
        end
      endcase
    end
    // a fresh cycle always begins with no edge recorded
    if (state_d != WWS_CYCLE) begin
      seen_d = 1'b0;
    end
  end

  // tick counter within a state; wraps at the end of each wake-up period
  always_comb begin
    cnt_d = cnt_q;
    if (state_d != state_q) begin
      cnt_d = '0;
    end else if (cyc_end && state_q == WWS_CYCLE) begin
      cnt_d = '0;
    end else if (tick) begin
      cnt_d = cnt_q + 4'h1;
    end
    // restarting the prescaler keeps each state's time whole; a fault restarts the delay
    tick_clr = (state_d != state_q) || (state_q == WWS_HOLD && !(out_ok && pins_s.in_good));
  end

  // outputs from next state so they change on the same edge as the state
  always_comb begin
    reset_n_d = (state_d != WWS_HOLD);
    wake_d    = (state_d == WWS_CYCLE) && (cnt_d < HALF_TICKS) && !seen_d;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q   <= WWS_HOLD;
      cnt_q     <= '0;
      seen_q    <= 1'b0;
      reset_n_q <= 1'b0;
      wake_q    <= 1'b0;
      reg_on_q  <= 1'b0;
      cause_q   <= WWS_CAUSE_POWER;
      tocnt_q   <= 8'h00;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      seen_q    <= seen_d;
      reset_n_q <= reset_n_d;
      wake_q    <= wake_d;
      reg_on_q  <= reg_on_d;
      cause_q   <= cause_d;
      tocnt_q   <= tocnt_d;
    end
  end

  assign reset_n_o      = reset_n_q;
  assign wakeup_o       = wake_q;
  assign regulator_on_o = reg_on_q;

  // ==========================================================================
  // avalon-mm slave: one wait cycle, then a one-cycle answer
  // ==========================================================================
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wr_word;
  logic [31:0] status_w;

  always_comb begin
    status_w = '0;
    status_w[ST_RESET_N] = reset_n_q;
    status_w[ST_WAKEUP]  = wake_q;
    status_w[ST_REG_ON]  = reg_on_q;
    status_w[ST_SEEN]    = seen_q;
    status_w[ST_OUT_OK]  = pins_s.out_good;
    status_w[ST_IN_OK]   = pins_s.in_good;
    status_w[ST_TOCNT +: 8] = tocnt_q;
    status_w[ST_CAUSE +: 2] = cause_q;
  end

  // the answer is computed while waitrequest is still high; write lands on the release edge
  always_comb begin
    wait_d   = 1'b1;
    rdata_d  = rdata_q;
    rdelay_d = rdelay_q;
    wr_word  = {{(32 - RDLY_W){1'b0}}, rdelay_q};
    for (int i = 0; i < 4; i++) begin
      if (avs_byteenable_i[i]) begin
        wr_word[8*i +: 8] = avs_writedata_i[8*i +: 8];
      end
    end
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
      case (avs_address_i)
        REG_RDELAY: rdata_d = {{(32 - RDLY_W){1'b0}}, rdelay_q};
        REG_STATUS: rdata_d = status_w;
        default:    rdata_d = '0;
      endcase
    end
    if (avs_write_i && !wait_q && avs_address_i == REG_RDELAY) begin
      rdelay_d = wr_word[RDLY_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wait_q   <= 1'b1;
      rdata_q  <= '0;
      rdelay_q <= RDELAY_DEFAULT;
    end else begin
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
      rdelay_q <= rdelay_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_wake_in_reset: assert property (!reset_n_q |-> !wake_q)
    else $error("wake-up high while reset asserted");

  a_input_low_resets: assert property (!pins_s.in_good |=> !reset_n_q)
    else $error("input low did not assert reset");

  a_output_low_resets: assert property (!pins_s.out_good |=> !reset_n_q)
    else $error("output low did not assert reset");

  a_release_when_good: assert property ($rose(reset_n_q) |-> $past(out_ok && pins_s.in_good))
    else $error("reset released while not in regulation");

  a_restart_cycle: assert property ($rose(reset_n_q) |-> state_q == WWS_RHW && cnt_q == '0)
    else $error("wake-up cycle not restarted after reset");

  a_wdog_forces_low: assert property (
    (state_q == WWS_CYCLE) && wd_fall && !cyc_end && out_ok && pins_s.in_good |=> !wake_q && seen_q)
    else $error("watchdog edge did not force wake-up low");

  a_ignore_repeat: assert property (
    (state_q == WWS_CYCLE) && seen_q && !cyc_end && out_ok && pins_s.in_good |=> seen_q && reset_n_q)
    else $error("second watchdog pulse changed the cycle");

  a_timeout_reset: assert property (
    (state_q == WWS_CYCLE) && cyc_end && !seen_q && !wd_fall |=> !reset_n_q)
    else $error("missed watchdog edge gave no reset");

  a_wake_half_high: assert property (wake_q |-> state_q == WWS_CYCLE && cnt_q < HALF_TICKS)
    else $error("wake-up high outside first half of the period");

  a_regulator_follows: assert property (reg_on_q == $past(pins_s.enable))
    else $error("regulator state does not follow enable");

  a_bus_one_answer: assert property (!wait_q |=> wait_q)
    else $error("waitrequest low for more than one cycle");

endmodule

// ---- sim/wws_mcu.sv ----
// wws_mcu: sleeping microcontroller that answers each wake-up rise with watchdog pulses.
// assumes the supervisor clock; mode 0 stays silent, 1 one pulse, 2 two pulses.
`timescale 1ns/1ps
module wws_mcu (
  input  wire logic       ref_clk_i,  // 200 MHz clock
  input  wire logic       wakeup_i,   // wake-up from the supervisor
  input  wire logic [1:0] mode_i,     // answer mode
  output      logic       watchdog_o  // watchdog_input, idles high
);
  // watchdog_o has a single driver; it settles high at the first edge, well inside reset
  int   cnt  = 0;
  logic last = 1'b0;
  // =====
  // pulse after a fixed wait; 1002 clocks keeps clear of the 5 us minimum
  always @(posedge ref_clk_i) begin
    last <= wakeup_i;
    if (cnt >= 1300) cnt <= 0;
    else if (wakeup_i && !last && mode_i != 2'h0) cnt <= 1;
    else if (cnt != 0) cnt <= cnt + 1;
    watchdog_o <= !((cnt >= 1002 && cnt < 1022) || (mode_i == 2'h2 && cnt >= 1200 && cnt < 1220));
  end
endmodule

// ---- sim/wws_top_bench.sv ----
// wws_top_bench: directed checks of wake-up timing, watchdog and reset causes.
// assumes a 40 ohm resistor setting so one tick is about 417 clocks.
`timescale 1ns/1ps
module wws_top_bench;
  import wws_pkg::*;
  localparam logic [RDLY_W-1:0] RD = 20'h00028;
  localparam int EXP_HALF = 40 * WAKE_PERIOD_TENTHS_NS / (2 * CLK_PERIOD_TENTHS_NS);
  localparam int EXP_RST  = 40 * RST_DELAY_TENTHS_NS / CLK_PERIOD_TENTHS_NS;
  localparam int EXP_RHW  = 40 * RST_TO_WAKE_TENTHS_NS / CLK_PERIOD_TENTHS_NS;
  localparam int EXP_NEXT = 2 * EXP_HALF - 1006;
  logic              ref_clk_i, reset_i, out_good_i, in_good_i, enable_i, watchdog;
  logic              reset_n_o, wakeup_o, regulator_on_o, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [ADDR_W-1:0] avs_address_i;
  logic [31:0]       avs_writedata_i, avs_readdata_o, rd;
  logic [3:0]        avs_byteenable_i;
  logic [1:0]        mode;
  int                n_errors, checked, n;

  wws_top #(.RDELAY_DEFAULT(RD)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .watchdog_input_i(watchdog),
    .out_good_i(out_good_i), .in_good_i(in_good_i), .enable_i(enable_i),
    .reset_n_o(reset_n_o), .wakeup_o(wakeup_o), .regulator_on_o(regulator_on_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  wws_mcu mcu_u (.ref_clk_i(ref_clk_i), .wakeup_i(wakeup_o), .mode_i(mode), .watchdog_o(watchdog));

  // =====
  // clock and checking helpers
  always #2.5 ref_clk_i = ~ref_clk_i;

  task end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // timing spread of the prescaler and synchronisers is tolerated, not hidden
  function automatic logic [31:0] near(input int v, input int e, input int tol);
    near = (v >= e - tol && v <= e + tol) ? 32'(e) : 32'(v);
  endfunction

  // counts falling clock edges until an output reaches a level, bounded
  task wait_for(input int which, input logic lvl, output int cnt);
    cnt = 0;
    while (cnt < 5000 && (which == 0 ? reset_n_o : which == 1 ? wakeup_o : regulator_on_o) !== lvl) begin
      @(negedge ref_clk_i);
      cnt++;
    end
    if (cnt >= 5000) begin
      n_errors++;
      $display("wrong value wait %0d expected %0b seen timeout", which, lvl);
      end_sim();
    end
  endtask

  // one avalon access held until waitrequest is sampled low
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd, output logic [31:0] q);
    int k;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      $display("wrong value bus expected answer seen timeout");
      end_sim();
    end
  endtask

  // =====
  // main sequence
  initial begin
    ref_clk_i = 0; reset_i = 1; out_good_i = 0; in_good_i = 1; enable_i = 1; mode = 2'h0;
    avs_address_i = '0; avs_read_i = 0; avs_write_i = 0; avs_writedata_i = '0; avs_byteenable_i = 4'hF;
    n_errors = 0; checked = 0;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, REG_RDELAY, 32'h0, rd); chk("rdelay reset", rd, 32'(RD));
    bus(1'b1, REG_RDELAY, 32'hFFF00028, rd);
    bus(1'b0, REG_RDELAY, 32'h0, rd); chk("rdelay upper", rd, 32'h00000028);
    // a single lane must touch only its own byte of the resistor setting
    avs_byteenable_i <= 4'h2;
    bus(1'b1, REG_RDELAY, 32'h00005500, rd);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, REG_RDELAY, 32'h0, rd); chk("rdelay lane", rd, 32'h00005528);
    bus(1'b1, REG_RDELAY, 32'(RD), rd);
    bus(1'b0, 2'h2, 32'h0, rd); chk("unmapped", rd, 32'h0);
    bus(1'b1, REG_STATUS, 32'hFFFFFFFF, rd);
    bus(1'b0, REG_STATUS, 32'h0, rd); chk("status reset_n", rd[0], 32'h0);
    repeat (2000) @(negedge ref_clk_i);
    chk("reset_n held", reset_n_o, 1'b0);
    chk("wake in hold", wakeup_o, 1'b0);
    @(posedge ref_clk_i); out_good_i <= 1'b1;
    wait_for(0, 1'b1, n); chk("powerup", near(n, EXP_RST + 5, 6), EXP_RST + 5);
    $display("test power-up done");
    wait_for(1, 1'b1, n); chk("reset to wake", near(n, EXP_RHW, 10), EXP_RHW);
    wait_for(1, 1'b0, n); chk("wake high", near(n, EXP_HALF, 10), EXP_HALF);
    wait_for(0, 1'b0, n); chk("wake low", near(n, EXP_HALF, 10), EXP_HALF);
    chk("wake in reset", wakeup_o, 1'b0);
    wait_for(0, 1'b1, n); chk("reset pulse", near(n, EXP_RST, 10), EXP_RST);
    bus(1'b0, REG_STATUS, 32'h0, rd); chk("cause", rd[17:8], 10'h301);
    wait_for(1, 1'b1, n); chk("restart", near(n, EXP_RHW, 10), EXP_RHW);
    $display("test timeout done");
    for (int i = 0; i < 3; i++) begin
      mode = (i == 0) ? 2'h2 : 2'h1;
      wait_for(1, 1'b0, n); chk("wake forced low", near(n, 1006, 6), 1006);
      wait_for(1, 1'b1, n); chk("next rise", near(n, EXP_NEXT, 12), EXP_NEXT);
      chk("no reset", reset_n_o, 1'b1);
    end
    $display("test watchdog done");
    @(posedge ref_clk_i); out_good_i <= 1'b0;
    wait_for(0, 1'b0, n); chk("out drop", near(n, 4, 2), 4);
    repeat (300) @(negedge ref_clk_i);
    chk("out held", reset_n_o, 1'b0);
    chk("wake out drop", wakeup_o, 1'b0);
    @(posedge ref_clk_i); out_good_i <= 1'b1;
    wait_for(0, 1'b1, n); chk("out recover", near(n, EXP_RST + 5, 6), EXP_RST + 5);
    @(posedge ref_clk_i); in_good_i <= 1'b0;
    wait_for(0, 1'b0, n); chk("in drop", near(n, 4, 2), 4);
    bus(1'b0, REG_STATUS, 32'h0, rd); chk("in drop cause", rd[17:16], 32'h2);
    @(posedge ref_clk_i); in_good_i <= 1'b1;
    wait_for(0, 1'b1, n); chk("in recover", near(n, EXP_RST + 5, 6), EXP_RST + 5);
    $display("test supply done");
    @(posedge ref_clk_i); enable_i <= 1'b0;
    wait_for(2, 1'b0, n); chk("reg off", near(n, 3, 2), 3);
    wait_for(0, 1'b0, n); chk("disabled reset", reset_n_o, 1'b0);
    @(posedge ref_clk_i); enable_i <= 1'b1;
    wait_for(2, 1'b1, n); chk("reg on", near(n, 3, 2), 3);
    $display("test enable done");
    end_sim();
  end
endmodule
